// ===== src/stop_mode_power_sequencer.sv
// top: stop mode power sequencer with AHB-Lite registers and power/pin latch outputs
// assumes one hclk domain; stop instruction is a one-cycle pulse from the core
// How it works
// - stop without enable forces illegal opcode reset
// - deep stop needs select, enable, detector not enabled in stop
// - detector running in stop gives shallow stop
// - deep stop: logic off, RAM kept, timer optional
// - pins latched at deep entry until acknowledge
// - deep exit on reset, irq or timer
// - irq pin is active-low wake in deep
// - irq pullup only when pin function enabled
// - deep wake gives power-on reset, pins stay latched
// - shallow stop: standby, optional clock and converter
`default_nettype none
module stop_mode_power_sequencer
    import stop_seq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic stop_instr,
    input wire logic reset_pin_n,
    input wire logic irq_pin,
    input wire logic wakeup_timer_irq,
    input wire logic [pin_count-1:0] pin_out_live,
    output logic [pin_count-1:0] pin_out_held,
    output logic pins_latched,
    output logic core_power_on,
    output logic core_standby,
    output logic ram_standby,
    output logic regulator_standby,
    output logic clock_gen_run,
    output logic converter_run,
    output logic wakeup_timer_run,
    output logic irq_pullup_en,
    output logic force_reset,
    output logic illegal_opcode_reset,
    output logic por_reset
);
    reg_link_if link ();

    ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .link(link)
    );

    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;

    power_state_e state_ff;
    logic latched_ff;
    logic illegal_ff;
    logic por_ff;
    logic force_ff;
    logic [2:0] rst_cnt_ff;
    logic deep_wake_ff;
    logic core_on_ff, core_sb_ff, ram_sb_ff, reg_sb_ff;
    logic clk_run_ff, conv_run_ff, tmr_run_ff, pullup_ff;

    //////////////////////////////////////////////////////////////////////////
    // stop decode
    wire stop_now = (stop_instr || link.stop_pulse) && state_ff == run_st;
    wire stop_ok = link.pmc[stop_entry_enable_bit];
    wire lvd_in_stop = link.pmc[lowvolt_detect_enable_bit]
        && link.pmc[lowvolt_detect_stop_enable_bit];
    wire go_illegal = stop_now && !stop_ok;
    wire go_deep = stop_now && stop_ok && link.pmc[deep_stop_select_bit]
        && !lvd_in_stop;
    wire go_shallow = stop_now && stop_ok && !go_deep;
    // deep stop ignores irq edge config: low level always wakes
    wire irq_deep_wake = !irq_pin;
    // shallow wake honours the configured polarity
    wire irq_asserted = link.irqc[irq_edge_high_bit] ? irq_pin : !irq_pin;
    wire deep_wake = !reset_pin_n || irq_deep_wake || wakeup_timer_irq;
    wire shallow_wake = !reset_pin_n || wakeup_timer_irq
        || (link.irqc[irq_pin_function_enable_bit] && irq_asserted);
    wire wake_deep_now = state_ff == deep_st && deep_wake;

    //////////////////////////////////////////////////////////////////////////
    // power state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) state_ff <= run_st;
        else begin
            unique case (state_ff)
                run_st: begin
                    if (go_deep) state_ff <= deep_st;
                    else if (go_shallow) state_ff <= shallow_st;
                end
                deep_st: if (deep_wake) state_ff <= run_st;
                shallow_st: if (shallow_wake) state_ff <= run_st;
                default: state_ff <= run_st;
            endcase
        end
    end

    // pin latches: captured on deep entry, held until acknowledge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latched_ff <= 1'b0;
        end else if (go_deep) begin
            latched_ff <= 1'b1;
        end else if (link.ack_pulse && state_ff == run_st) begin
            latched_ff <= 1'b0;
        end
    end

    // pins follow live values unless latched; shallow holds them too
    genvar gi;
    generate
        for (gi = 0; gi < pin_count; gi++) begin : g_pin
            logic pin_ff;
            wire hold = latched_ff || state_ff == shallow_st;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) pin_ff <= 1'b0;
                else if (!hold && !go_deep && !go_shallow) pin_ff <= pin_out_live[gi];
            end
            assign pin_out_held[gi] = pin_ff;
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // forced reset pulse; a deep wake resets peripherals as power-on
    // but the pin latch is outside it, so pins survive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_ff <= 3'h0;
            force_ff <= 1'b0;
            illegal_ff <= 1'b0;
            por_ff <= 1'b0;
        end else if (go_illegal || wake_deep_now) begin
            rst_cnt_ff <= reset_pulse_cnt;
            illegal_ff <= go_illegal;
            por_ff <= wake_deep_now;
            force_ff <= 1'b1;
        end else if (rst_cnt_ff != 3'h0) begin
            rst_cnt_ff <= rst_cnt_ff - 3'h1;
        end else begin
            illegal_ff <= 1'b0;
            por_ff <= 1'b0;
            force_ff <= 1'b0;
        end
    end

    // sticky status of the last deep wake, cleared by pin acknowledge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) deep_wake_ff <= 1'b0;
        else if (wake_deep_now) deep_wake_ff <= 1'b1;
        else if (link.ack_pulse) deep_wake_ff <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // power domain controls, registered from the next state
    wire nxt_deep = go_deep || (state_ff == deep_st && !deep_wake);
    wire nxt_shallow = go_shallow || (state_ff == shallow_st && !shallow_wake);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_on_ff <= 1'b1;
            core_sb_ff <= 1'b0;
            ram_sb_ff <= 1'b0;
            reg_sb_ff <= 1'b0;
            clk_run_ff <= 1'b1;
            conv_run_ff <= 1'b1;
            tmr_run_ff <= 1'b1;
        end else begin
            core_on_ff <= !nxt_deep;
            core_sb_ff <= nxt_shallow;
            ram_sb_ff <= nxt_deep || nxt_shallow;
            reg_sb_ff <= nxt_deep || nxt_shallow;
            clk_run_ff <= nxt_deep ? 1'b0 : nxt_shallow
                ? link.pmc[clock_run_in_stop_bit] : 1'b1;
            conv_run_ff <= nxt_deep ? 1'b0 : nxt_shallow
                ? link.pmc[converter_run_in_stop_bit] : 1'b1;
            tmr_run_ff <= (nxt_deep || nxt_shallow)
                ? link.pmc[wakeup_timer_run_in_stop_bit] : 1'b1;
        end
    end

    // pullup never forced on by deep stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pullup_ff <= 1'b0;
        else pullup_ff <= link.irqc[irq_pin_function_enable_bit]
            && !link.irqc[irq_pull_disable_bit];
    end

    // status: software saves state before deep entry and restores before ack
    assign link.status = {3'h0, deep_wake_ff, illegal_ff, latched_ff,
        state_ff == shallow_st, state_ff == deep_st};

    assign pins_latched = latched_ff;
    assign core_power_on = core_on_ff;
    assign core_standby = core_sb_ff;
    assign ram_standby = ram_sb_ff;
    assign regulator_standby = reg_sb_ff;
    assign clock_gen_run = clk_run_ff;
    assign converter_run = conv_run_ff;
    assign wakeup_timer_run = tmr_run_ff;
    assign irq_pullup_en = pullup_ff;
    assign force_reset = force_ff;
    assign illegal_opcode_reset = illegal_ff;
    assign por_reset = por_ff;
endmodule
`default_nettype wire

// ===== src/stop_seq_pkg.sv
// package: register map, field positions, reset values and states of the stop sequencer
// assumes a 32-bit AHB-Lite register bus on hclk
package stop_seq_pkg;
    // byte offsets of the registers
    localparam logic [7:0] power_mode_control_reg_off = 8'h00;
    localparam logic [7:0] irq_pin_control_reg_off = 8'h04;
    localparam logic [7:0] status_reg_off = 8'h08;
    localparam logic [7:0] stop_request_reg_off = 8'h0C;
    // power_mode_control_reg fields
    localparam int deep_stop_select_bit = 0;
    localparam int stop_entry_enable_bit = 1;
    localparam int lowvolt_detect_enable_bit = 2;
    localparam int lowvolt_detect_stop_enable_bit = 3;
    localparam int pin_latch_release_ack_bit = 4;
    localparam int clock_run_in_stop_bit = 5;
    localparam int converter_run_in_stop_bit = 6;
    localparam int wakeup_timer_run_in_stop_bit = 7;
    // irq_pin_control_reg fields
    localparam int irq_pin_function_enable_bit = 0;
    localparam int irq_pull_disable_bit = 1;
    localparam int irq_edge_high_bit = 2;
    // status register fields
    localparam int stat_deep_bit = 0;
    localparam int stat_shallow_bit = 1;
    localparam int stat_latched_bit = 2;
    localparam int stat_illegal_bit = 3;
    localparam int stat_deep_wake_bit = 4;
    // reset values
    localparam logic [7:0] pmc_reset = 8'h00;
    localparam logic [2:0] irqc_reset = 3'h0;
    // forced reset countdown start; the pulse is held one cycle more than this
    localparam int reset_pulse_cycles = 4;
    localparam logic [2:0] reset_pulse_cnt = 3'(reset_pulse_cycles);
    // number of latched I/O pins
    localparam int pin_count = 4;
    typedef enum logic [1:0] {run_st, deep_st, shallow_st} power_state_e;
endpackage

// ===== src/reg_link_if.sv
// interface: register values and events between bus slave and sequencer core
// assumes a single hclk domain
`default_nettype none
interface reg_link_if;
    import stop_seq_pkg::*;
    logic [7:0] pmc;
    logic [2:0] irqc;
    logic ack_pulse;
    logic stop_pulse;
    logic [7:0] status;
    modport bus (output pmc, output irqc, output ack_pulse, output stop_pulse, input status);
    modport core (input pmc, input irqc, input ack_pulse, input stop_pulse, output status);
endinterface
`default_nettype wire

// ===== src/ahb_regs.sv
// AHB-Lite slave holding the mode control and pin control registers
// assumes single word transfers; zero wait states, always OKAY
`default_nettype none
module ahb_regs
    import stop_seq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    reg_link_if.bus link
);
    logic [7:0] pmc_ff;
    logic [2:0] irqc_ff;
    logic wr_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff;

    // address phase capture
    wire take = hsel && htrans[1] && hready;
    wire wr_pmc = wr_ff && addr_ff == power_mode_control_reg_off;
    wire wr_irqc = wr_ff && addr_ff == irq_pin_control_reg_off;
    wire wr_stop = wr_ff && addr_ff == stop_request_reg_off;
    // read select on the address phase, so the data phase shows it from a flop
    wire [31:0] rd_mux = haddr == power_mode_control_reg_off ? {24'h000000, pmc_ff} :
        haddr == irq_pin_control_reg_off ? {29'h00000000, irqc_ff} :
        haddr == status_reg_off ? {24'h000000, link.status} : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else begin
            wr_ff <= take && hwrite;
            addr_ff <= take ? haddr : addr_ff;
        end
    end

    // ack bit is write-only: stored as zero, only pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmc_ff <= pmc_reset;
            irqc_ff <= irqc_reset;
        end else begin
            if (wr_pmc) pmc_ff <= hwdata[7:0] & 8'hEF;
            if (wr_irqc) irqc_ff <= hwdata[2:0];
        end
    end

    // read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata_ff <= 32'h00000000;
        else if (take && !hwrite) hrdata_ff <= rd_mux;
    end

    assign hrdata = hrdata_ff;
    assign link.pmc = pmc_ff;
    assign link.irqc = irqc_ff;
    assign link.ack_pulse = wr_pmc && hwdata[pin_latch_release_ack_bit];
    assign link.stop_pulse = wr_stop && hwdata[0];
endmodule
`default_nettype wire

// ===== test/core_model.sv
// core model: turns a bench request into a one-cycle stop pulse and drives the port register
// assumes the bench raises exec_stop for one cycle just after an edge
`default_nettype none
module core_model
    import stop_seq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic exec_stop,
    input wire logic [pin_count-1:0] port_val,
    output logic stop_instr,
    output logic [pin_count-1:0] pin_out_live
);
    logic exec_d_ff;
    ////////////////////////////////////////
    // edge detect, so one request gives exactly one stop pulse
    // the port register is what software saves and later restores before the ack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_d_ff <= 1'b0;
            stop_instr <= 1'b0;
            pin_out_live <= '0;
        end else begin
            exec_d_ff <= exec_stop;
            stop_instr <= exec_stop && !exec_d_ff;
            pin_out_live <= port_val;
        end
    end
endmodule
`default_nettype wire

// ===== test/stop_seq_sva.sv
// checker: stop entry, wake and pin latch relations at the top ports
// assumes it is bound onto the sequencer top and sees only its ports
`default_nettype none
module stop_seq_sva
    import stop_seq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic stop_instr,
    input wire logic reset_pin_n,
    input wire logic irq_pin,
    input wire logic wakeup_timer_irq,
    input wire logic [pin_count-1:0] pin_out_held,
    input wire logic pins_latched,
    input wire logic core_power_on,
    input wire logic core_standby,
    input wire logic ram_standby,
    input wire logic regulator_standby,
    input wire logic irq_pullup_en,
    input wire logic force_reset,
    input wire logic illegal_opcode_reset,
    input wire logic por_reset
);
    logic [7:0] wa_ff;
    logic wv_ff;
    logic [7:0] pmc_ff;
    logic pe_ff;
    ////////////////////////////////////////
    // running and deep-eligible decode
    wire logic run = core_power_on && !core_standby && !force_reset;
    wire logic deep_ok = pmc_ff[0] && !(pmc_ff[2] && pmc_ff[3]);
    // shadow of the control bits, updated at end of data phase like the slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_ff <= 1'b0;
            wa_ff <= 8'h00;
            pmc_ff <= 8'h00;
            pe_ff <= 1'b0;
        end else if (hready) begin
            wv_ff <= hsel && htrans[1] && hwrite;
            wa_ff <= haddr;
            if (wv_ff && wa_ff == power_mode_control_reg_off) pmc_ff <= hwdata[7:0];
            if (wv_ff && wa_ff == irq_pin_control_reg_off) pe_ff <= hwdata[0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_illegal_stop: assert property (stop_instr && run && !pmc_ff[1] |=>
        core_power_on && !core_standby ##[0:1] (force_reset && illegal_opcode_reset))
        else $error("stop without enable did not force an illegal reset");
    a_deep_entry: assert property (stop_instr && run && pmc_ff[1] && deep_ok |=>
        !core_power_on && ram_standby && regulator_standby && pins_latched)
        else $error("deep stop entry outputs wrong");
    a_shallow_entry: assert property (stop_instr && run && pmc_ff[1] && !deep_ok |=>
        core_power_on && core_standby && ram_standby)
        else $error("shallow stop entry outputs wrong");
    a_pins_frozen: assert property (pins_latched ##1 pins_latched |->
        $stable(pin_out_held))
        else $error("latched pins changed");
    a_deep_quiet: assert property (!core_power_on && reset_pin_n && irq_pin
        && !wakeup_timer_irq |=> !core_power_on)
        else $error("deep stop left without a wake source");
    a_irq_wake: assert property (!core_power_on && !irq_pin |-> ##[1:4] core_power_on)
        else $error("low irq pin did not wake from deep stop");
    a_wake_por: assert property ($rose(core_power_on) |->
        ##[0:1] (force_reset && por_reset && pins_latched))
        else $error("deep wake without power-on reset or latch");
    a_pullup_gate: assert property (!core_power_on && !pe_ff |-> !irq_pullup_en)
        else $error("irq pullup on without pin function enable");
endmodule
bind stop_mode_power_sequencer stop_seq_sva stop_seq_sva_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .stop_instr,
    .reset_pin_n, .irq_pin, .wakeup_timer_irq, .pin_out_held, .pins_latched,
    .core_power_on, .core_standby, .ram_standby, .regulator_standby, .irq_pullup_en,
    .force_reset, .illegal_opcode_reset, .por_reset
);
`default_nettype wire

// ===== test/stop_mode_power_sequencer_tb.sv
// bench: registers, illegal stop, shallow stop, and deep stop with each wake source
// assumes the core model and the bound checker compile alongside
`default_nettype none
module stop_mode_power_sequencer_tb
    import stop_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, exec_stop, reset_pin_n, irq_pin, wakeup_timer_irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d, w;
    logic [pin_count-1:0] port_val, pin_out_live, pin_out_held, exp_pins;
    logic hreadyout, stop_instr, pins_latched, core_power_on, core_standby, ram_standby;
    logic regulator_standby, clock_gen_run, converter_run, wakeup_timer_run, irq_pullup_en;
    logic force_reset, illegal_opcode_reset, por_reset, saw, hresp;
    int fails = 0, n_compared = 0, seed = 43698;
    ////////////////////////////////////////
    stop_mode_power_sequencer stop_mode_power_sequencer_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .stop_instr, .reset_pin_n, .irq_pin,
        .wakeup_timer_irq, .pin_out_live, .pin_out_held, .pins_latched, .core_power_on,
        .core_standby, .ram_standby, .regulator_standby, .clock_gen_run, .converter_run,
        .wakeup_timer_run, .irq_pullup_en, .force_reset, .illegal_opcode_reset, .por_reset);
    core_model core_model_inst (.hclk, .hresetn, .exec_stop, .port_val, .stop_instr,
        .pin_out_live);
    // 50 ns clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] pmc_exp(input logic [31:0] v);
        return {24'h0, v[7:5], 1'b0, v[3:0]}; // ack bit always reads 0
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer; waits on hready with no assumed latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk({hreadyout, hresp}, 2'b10);
    endtask
    task automatic stop();
        @(posedge hclk);
        exec_stop <= 1'b1;
        @(posedge hclk);
        exec_stop <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        finish_test();
    end
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, exec_stop, wakeup_timer_irq} = 5'h00;
        {reset_pin_n, irq_pin, haddr, htrans, hsize} = {2'b11, 8'h00, 2'h0, 3'h2};
        hwdata = 32'h0;
        port_val = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, status_reg_off, 0);
        chk(d, 0);
        w = $random(seed);
        bus(1, power_mode_control_reg_off, w);
        bus(0, power_mode_control_reg_off, 0);
        chk(d, pmc_exp(w));
        bus(1, irq_pin_control_reg_off, w);
        bus(0, irq_pin_control_reg_off, 0);
        chk(d, {29'h0, w[2:0]});
        bus(1, 8'h10, w);
        bus(0, 8'h10, 0);
        chk(d, 0);
        $display("test registers done");
        bus(1, power_mode_control_reg_off, w & 32'hFD);
        stop();
        chk(force_reset && illegal_opcode_reset, 1);
        chk(core_power_on && !core_standby, 1);
        repeat (8) @(posedge hclk);
        $display("test illegal stop done");
        // select 0, select 1 overridden by the detector, then a software stop request
        // irq config rewritten each pass: a random one could wake shallow at once
        for (int k = 0; k < 3; k++) begin
            bus(1, irq_pin_control_reg_off, (k == 1) ? 32'h1 : 32'h0);
            port_val <= 4'($random(seed));
            w = ($random(seed) & 32'hE0) | 32'h02 | ((k == 1) ? 32'h0D : 32'h0);
            bus(1, power_mode_control_reg_off, w);
            exp_pins = port_val;
            if (k == 2) begin
                bus(1, stop_request_reg_off, 1);
                repeat (4) @(posedge hclk);
            end else begin
                stop();
            end
            port_val <= ~exp_pins;
            chk({core_power_on, core_standby}, 2'b11);
            chk({wakeup_timer_run, converter_run, clock_gen_run}, w[7:5]);
            repeat (3) @(posedge hclk);
            chk(pin_out_held, exp_pins);
            if (k == 1) irq_pin <= 1'b0;
            else wakeup_timer_irq <= 1'b1;
            while (core_standby !== 1'b0) @(posedge hclk);
            {irq_pin, wakeup_timer_irq} <= 2'b10;
        end
        $display("test shallow stop done");
        // deep stop, woken by reset pin, irq pin, timer in turn
        for (int s = 0; s < 3; s++) begin
            bus(1, irq_pin_control_reg_off, (s == 1) ? 32'h5 : 32'h0);
            port_val <= 4'($random(seed));
            w = ($random(seed) & 32'hA4) | 32'h03;
            bus(1, power_mode_control_reg_off, w);
            exp_pins = port_val;
            stop();
            chk({core_power_on, core_standby, regulator_standby, ram_standby}, 4'h3);
            chk({clock_gen_run, converter_run, wakeup_timer_run}, {2'b00, w[7]});
            chk({pins_latched, pin_out_held}, {1'b1, exp_pins});
            chk(irq_pullup_en, s == 1);
            port_val <= ~exp_pins;
            repeat (3) @(posedge hclk);
            chk(core_power_on, 0);
            if (s == 0) reset_pin_n <= 1'b0;
            else if (s == 1) irq_pin <= 1'b0;
            else wakeup_timer_irq <= 1'b1;
            while (core_power_on !== 1'b1) @(posedge hclk);
            saw = 1'b0;
            repeat (8) begin
                @(posedge hclk);
                saw = saw | por_reset;
            end
            {reset_pin_n, irq_pin, wakeup_timer_irq} <= 3'b110;
            chk(saw, 1);
            chk({pins_latched, pin_out_held}, {1'b1, exp_pins});
            bus(0, status_reg_off, 0);
            chk(d[stat_deep_wake_bit], 1);
            port_val <= exp_pins;
            bus(1, power_mode_control_reg_off, 32'h10);
            repeat (2) @(posedge hclk);
            chk({pins_latched, pin_out_held}, {1'b0, exp_pins});
        end
        $display("test deep stop done");
        finish_test();
    end
endmodule
`default_nettype wire
